// file: shared/rst_cause_pkg.sv
package rst_cause_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int PC_W     = 15;
   localparam int STATUS_W = 5;
   localparam int PCS_W    = 6;
   localparam int DEPTH_W  = 5;

   // -----------------------------------------------------------------
   // Program counter load values
   // -----------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RESET_ADDR  = 15'h0000;
   localparam logic [PC_W-1:0] PC_INT_VECTOR  = 15'h0004;

   // -----------------------------------------------------------------
   // Status low field: timeout, powerdown, then the three ALU flags
   // -----------------------------------------------------------------
   localparam int ST_TIMEOUT_BIT   = 4;
   localparam int ST_POWERDOWN_BIT = 3;
   localparam logic [STATUS_W-1:0] ST_ALU_MASK    = 5'h07;
   localparam logic [STATUS_W-1:0] ST_POR_VALUE   = 5'h18;

   // -----------------------------------------------------------------
   // Power-control status field, top bit first:
   // stack overflow, stack underflow, external pin, reset instruction,
   // power-on, brown-out. Reset flags are active low.
   // -----------------------------------------------------------------
   localparam int PCS_OVF_BIT = 5;
   localparam int PCS_UNF_BIT = 4;
   localparam int PCS_PIN_BIT = 3;
   localparam int PCS_INS_BIT = 2;
   localparam int PCS_POR_BIT = 1;
   localparam int PCS_BOR_BIT = 0;
   // Brown-out bit powers up unknown; it is taken as 0 here
   localparam logic [PCS_W-1:0] PCS_POR_VALUE = 6'h0C;

   // -----------------------------------------------------------------
   // Stack
   // -----------------------------------------------------------------
   localparam logic [DEPTH_W-1:0] STACK_LEVELS = 5'h10;
   localparam logic [DEPTH_W-1:0] DEPTH_ONE    = 5'h01;
   localparam logic [DEPTH_W-1:0] DEPTH_ZERO   = 5'h00;

   // -----------------------------------------------------------------
   // Reset and wake causes, and the flag updates each one makes
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      CAUSE_NONE      = 4'h0,
      CAUSE_BROWNOUT  = 4'h1,
      CAUSE_PIN_RUN   = 4'h2,
      CAUSE_PIN_SLEEP = 4'h3,
      CAUSE_WD_RESET  = 4'h4,
      CAUSE_WD_WAKE   = 4'h5,
      CAUSE_INT_WAKE  = 4'h6,
      CAUSE_RESET_INS = 4'h7,
      CAUSE_STK_OVF   = 4'h8,
      CAUSE_STK_UNF   = 4'h9
   } cause_t;

   typedef struct packed {
      logic [STATUS_W-1:0] st_set;
      logic [STATUS_W-1:0] st_clr;
      logic [PCS_W-1:0]    pc_set;
      logic [PCS_W-1:0]    pc_clr;
   } cause_masks_t;

   typedef enum logic [1:0] {
      SEQ_RUN       = 2'h0,
      SEQ_HOLD      = 2'h1,
      SEQ_WAKE_STEP = 2'h2
   } seq_state_t;

   // Bits outside both masks keep their value
   function automatic cause_masks_t cause_masks(input cause_t c);
      cause_masks_t m;
      m = '0;
      case (c)
         CAUSE_BROWNOUT: begin
            m.st_set = 5'h18;
            m.pc_set = 6'h0C;
            m.pc_clr = 6'h31;
         end
         CAUSE_PIN_RUN: begin
            m.pc_clr = 6'h08;
         end
         CAUSE_PIN_SLEEP: begin
            m.st_set = 5'h10;
            m.st_clr = 5'h08;
            m.pc_clr = 6'h08;
         end
         CAUSE_WD_RESET: begin
            m.st_clr = 5'h10;
         end
         CAUSE_WD_WAKE: begin
            m.st_clr = 5'h18;
         end
         CAUSE_INT_WAKE: begin
            m.st_set = 5'h10;
            m.st_clr = 5'h08;
         end
         CAUSE_RESET_INS: begin
            m.pc_clr = 6'h04;
         end
         CAUSE_STK_OVF: begin
            m.pc_set = 6'h20;
         end
         CAUSE_STK_UNF: begin
            m.pc_set = 6'h10;
         end
         default: begin
            m = '0;
         end
      endcase
      return m;
   endfunction

   // -----------------------------------------------------------------
   // Module state carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH_W-1:0] depth;
      logic               overflow;
      logic               underflow;
   } stack_state_t;

   typedef struct packed {
      seq_state_t          seq;
      logic [1:0]          pin_sync;
      logic                brownout_q;
      logic [STATUS_W-1:0] status;
      logic [PCS_W-1:0]    pcs;
      logic                core_reset;
      logic                pc_load;
      logic [PC_W-1:0]     pc_value;
      logic                resume;
      logic                vector_push;
      cause_t              last_cause;
   } loader_state_t;

endpackage

// file: verilog/stack_depth_guard.sv
`timescale 1ns/1ps
module stack_depth_guard (
   // Clock and control
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic clear_i,
   input  wire logic enable_i,
   // Stack activity from the core
   input  wire logic push_i,
   input  wire logic pop_i,
   // Fault pulses
   output logic      overflow_o,
   output logic      underflow_o
);

   rst_cause_pkg::stack_state_t st;
   rst_cause_pkg::stack_state_t next_st;

   // ------------------------------------------------------------------
   // Depth tracking
   // ------------------------------------------------------------------
   // Disabled, the depth wraps like a circular stack, unreported.
   always_comb begin
      next_st = st;
      next_st.overflow = 1'b0;
      next_st.underflow = 1'b0;
      if (clear_i) begin
         next_st.depth = rst_cause_pkg::DEPTH_ZERO;
      end else if (push_i && !pop_i) begin
         if (st.depth == rst_cause_pkg::STACK_LEVELS) begin
            next_st.overflow = enable_i;
            next_st.depth = rst_cause_pkg::DEPTH_ONE;
         end else begin
            next_st.depth = st.depth + rst_cause_pkg::DEPTH_ONE;
         end
      end else if (pop_i && !push_i) begin
         if (st.depth == rst_cause_pkg::DEPTH_ZERO) begin
            next_st.underflow = enable_i;
            next_st.depth = rst_cause_pkg::STACK_LEVELS;
         end else begin
            next_st.depth = st.depth - rst_cause_pkg::DEPTH_ONE;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign overflow_o  = st.overflow;
   assign underflow_o = st.underflow;

endmodule

// file: verilog/reset_cause_state_loader.sv
// Notes on behaviour
// - All resets load program counter with 0000h.
// - Power-on and brown-out preset status, power-control.
// - Pin reset running: clear pin flag only.
// - Pin reset asleep: timeout set, powerdown, pin cleared.
// - Watchdog reset clears timeout; wake clears both.
// - Interrupt wake: continue, timeout set, powerdown cleared.
// - Interrupt wake with interrupts enabled: step, push, vector.
// - Reset instruction clears only its own flag.
// - Enabled stack overflow sets overflow flag only.
// - Enabled stack underflow sets underflow flag only.
// - Unassigned bits keep their previous value.
// - Enabled stack faults beyond sixteen levels reset.
`timescale 1ns/1ps
module reset_cause_state_loader (
   // Clock, power-on reset and clock enable
   input  wire logic                              mclk_i,
   input  wire logic                              rst_i,
   input  wire logic                              ce_i,
   // Reset and wake sources
   input  wire logic                              ext_reset_pin_n_i,
   input  wire logic                              brownout_i,
   input  wire logic                              watchdog_timeout_i,
   input  wire logic                              int_wake_i,
   input  wire logic                              reset_instr_i,
   // Core state and configuration
   input  wire logic                              asleep_i,
   input  wire logic                              global_int_enable_i,
   input  wire logic                              stack_fault_reset_enable_i,
   input  wire logic                              instr_done_i,
   input  wire logic                              push_i,
   input  wire logic                              pop_i,
   // Software and ALU access to the flags
   input  wire logic                              alu_flags_we_i,
   input  wire logic [rst_cause_pkg::STATUS_W-1:0] alu_flags_i,
   input  wire logic [rst_cause_pkg::PCS_W-1:0]    pcs_sw_set_i,
   input  wire logic [rst_cause_pkg::PCS_W-1:0]    pcs_sw_clr_i,
   // Core sequencing
   output logic                                   core_reset_o,
   output logic                                   pc_load_o,
   output logic [rst_cause_pkg::PC_W-1:0]          pc_value_o,
   output logic                                   resume_o,
   output logic                                   vector_push_o,
   // Flag registers
   output logic [rst_cause_pkg::STATUS_W-1:0]      status_o,
   output logic [rst_cause_pkg::PCS_W-1:0]         power_control_status_o,
   output logic [3:0]                             last_cause_o
);

   rst_cause_pkg::loader_state_t r;
   rst_cause_pkg::loader_state_t next_r;

   logic                         stk_ovf;
   logic                         stk_unf;
   logic                         pin_low;
   logic                         brownout_rise;
   rst_cause_pkg::cause_t        cause;
   rst_cause_pkg::cause_masks_t  m;

   // ------------------------------------------------------------------
   // Stack fault detection
   // ------------------------------------------------------------------
   // The depth is forgotten while the core is held, since the stack
   // pointer restarts from empty after every reset.
   stack_depth_guard u_stack_guard (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .clear_i     (r.core_reset),
      .enable_i    (stack_fault_reset_enable_i),
      .push_i      (push_i),
      .pop_i       (pop_i),
      .overflow_o  (stk_ovf),
      .underflow_o (stk_unf)
   );

   // ------------------------------------------------------------------
   // Cause selection
   // ------------------------------------------------------------------
   // Logic reads only the second synchroniser stage.
   assign pin_low       = !r.pin_sync[1];
   assign brownout_rise = brownout_i && !r.brownout_q;

   // One winner per event, by severity, so flag updates never mix.
   always_comb begin
      cause = rst_cause_pkg::CAUSE_NONE;
      if (r.seq == rst_cause_pkg::SEQ_HOLD) begin
         // A held core only notices a fresh brown-out
         if (brownout_rise) begin
            cause = rst_cause_pkg::CAUSE_BROWNOUT;
         end
      end else if (brownout_i) begin
         cause = rst_cause_pkg::CAUSE_BROWNOUT;
      end else if (pin_low) begin
         if (asleep_i) begin
            cause = rst_cause_pkg::CAUSE_PIN_SLEEP;
         end else begin
            cause = rst_cause_pkg::CAUSE_PIN_RUN;
         end
      end else if (watchdog_timeout_i) begin
         if (asleep_i) begin
            cause = rst_cause_pkg::CAUSE_WD_WAKE;
         end else begin
            cause = rst_cause_pkg::CAUSE_WD_RESET;
         end
      end else if (stk_ovf) begin
         cause = rst_cause_pkg::CAUSE_STK_OVF;
      end else if (stk_unf) begin
         cause = rst_cause_pkg::CAUSE_STK_UNF;
      end else if (reset_instr_i && !asleep_i) begin
         cause = rst_cause_pkg::CAUSE_RESET_INS;
      end else if (int_wake_i && asleep_i) begin
         cause = rst_cause_pkg::CAUSE_INT_WAKE;
      end
   end

   assign m = rst_cause_pkg::cause_masks(cause);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.pin_sync = {r.pin_sync[0], ext_reset_pin_n_i};
      next_r.brownout_q = brownout_i;
      next_r.pc_load = 1'b0;
      next_r.resume = 1'b0;
      next_r.vector_push = 1'b0;

      // Software and ALU writes first; an event on top wins.
      if (alu_flags_we_i) begin
         next_r.status = (r.status & ~rst_cause_pkg::ST_ALU_MASK)
                       | (alu_flags_i & rst_cause_pkg::ST_ALU_MASK);
      end
      next_r.pcs = (r.pcs & ~pcs_sw_clr_i) | pcs_sw_set_i;

      // Bits in neither mask are kept
      next_r.status = (next_r.status & ~m.st_clr) | m.st_set;
      next_r.pcs = (next_r.pcs & ~m.pc_clr) | m.pc_set;
      if (cause != rst_cause_pkg::CAUSE_NONE) begin
         next_r.last_cause = cause;
      end

      case (cause)
         rst_cause_pkg::CAUSE_BROWNOUT,
         rst_cause_pkg::CAUSE_PIN_RUN,
         rst_cause_pkg::CAUSE_PIN_SLEEP,
         rst_cause_pkg::CAUSE_WD_RESET,
         rst_cause_pkg::CAUSE_RESET_INS,
         rst_cause_pkg::CAUSE_STK_OVF,
         rst_cause_pkg::CAUSE_STK_UNF: begin
            next_r.seq = rst_cause_pkg::SEQ_HOLD;
            next_r.core_reset = 1'b1;
         end
         rst_cause_pkg::CAUSE_WD_WAKE: begin
            next_r.resume = 1'b1;
            next_r.seq = rst_cause_pkg::SEQ_RUN;
         end
         rst_cause_pkg::CAUSE_INT_WAKE: begin
            next_r.resume = 1'b1;
            if (global_int_enable_i) begin
               next_r.seq = rst_cause_pkg::SEQ_WAKE_STEP;
            end else begin
               next_r.seq = rst_cause_pkg::SEQ_RUN;
            end
         end
         default: begin
            case (r.seq)
               rst_cause_pkg::SEQ_HOLD: begin
                  // Released only once every held source has gone
                  if (!pin_low && !brownout_i) begin
                     next_r.seq = rst_cause_pkg::SEQ_RUN;
                     next_r.core_reset = 1'b0;
                     next_r.pc_load = 1'b1;
                     next_r.pc_value = rst_cause_pkg::PC_RESET_ADDR;
                  end
               end
               rst_cause_pkg::SEQ_WAKE_STEP: begin
                  // The instruction after sleep runs before vectoring
                  if (instr_done_i) begin
                     next_r.seq = rst_cause_pkg::SEQ_RUN;
                     next_r.vector_push = 1'b1;
                     next_r.pc_load = 1'b1;
                     next_r.pc_value = rst_cause_pkg::PC_INT_VECTOR;
                  end
               end
               rst_cause_pkg::SEQ_RUN: begin
                  next_r.seq = rst_cause_pkg::SEQ_RUN;
               end
               default: begin
                  next_r.seq = rst_cause_pkg::SEQ_HOLD;
                  next_r.core_reset = 1'b1;
               end
            endcase
         end
      endcase
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Power-on is the block reset itself. The synchroniser starts
   // released; a pin held low shows two cycles after release.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r <= '0;
         r.seq <= rst_cause_pkg::SEQ_HOLD;
         r.pin_sync <= 2'h3;
         r.status <= rst_cause_pkg::ST_POR_VALUE;
         r.pcs <= rst_cause_pkg::PCS_POR_VALUE;
         r.core_reset <= 1'b1;
         r.pc_value <= rst_cause_pkg::PC_RESET_ADDR;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign core_reset_o           = r.core_reset;
   assign pc_load_o              = r.pc_load;
   assign pc_value_o             = r.pc_value;
   assign resume_o               = r.resume;
   assign vector_push_o          = r.vector_push;
   assign status_o               = r.status;
   assign power_control_status_o = r.pcs;
   assign last_cause_o           = r.last_cause;

endmodule

// file: bench/core_seq_model.sv
`timescale 1ns/1ps
module core_seq_model (
   // Clock and reset
   input  wire logic                           mclk_i,
   input  wire logic                           rst_i,
   // Sequencing from the loader
   input  wire logic                           pc_load_i,
   input  wire logic [rst_cause_pkg::PC_W-1:0] pc_value_i,
   input  wire logic                           resume_i,
   // Core side results
   output logic                                instr_done_o,
   output logic [rst_cause_pkg::PC_W-1:0]      pc_o,
   output int                                  loads_o,
   output int                                  resumes_o
);
   // The woken instruction takes two cycles before the vector
   logic [1:0] wait_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wait_q <= 2'h0;
         pc_o <= '0;
         loads_o <= 0;
         resumes_o <= 0;
      end else begin
         wait_q <= {wait_q[0], resume_i};
         if (pc_load_i) begin
            pc_o <= pc_value_i;
            loads_o <= loads_o + 1;
         end else if (resume_i) begin
            pc_o <= pc_o + 15'h0001;
            resumes_o <= resumes_o + 1;
         end
      end
   end

   assign instr_done_o = wait_q[1];
endmodule

// file: bench/reset_cause_state_loader_asserts.sv
`timescale 1ns/1ps
module reset_cause_state_loader_asserts (
   // Clock and inputs
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        ext_reset_pin_n_i,
   input wire logic        brownout_i,
   input wire logic        watchdog_timeout_i,
   input wire logic        int_wake_i,
   input wire logic        reset_instr_i,
   input wire logic        asleep_i,
   input wire logic        stack_fault_reset_enable_i,
   input wire logic        push_i,
   input wire logic        pop_i,
   input wire logic        alu_flags_we_i,
   input wire logic [5:0]  pcs_sw_set_i,
   input wire logic [5:0]  pcs_sw_clr_i,
   // Outputs watched
   input wire logic        core_reset_o,
   input wire logic        pc_load_o,
   input wire logic [14:0] pc_value_o,
   input wire logic        resume_o,
   input wire logic        vector_push_o,
   input wire logic [4:0]  status_o,
   input wire logic [5:0]  power_control_status_o
);
   default clocking dcb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // Nothing else competes at this edge
   sequence quiet_s;
      ce_i && !core_reset_o && !brownout_i && ext_reset_pin_n_i
      && $past(ext_reset_pin_n_i) && $past(ext_reset_pin_n_i, 2)
      && !$past(push_i) && !$past(pop_i) && !alu_flags_we_i
      && pcs_sw_set_i == 6'h00 && pcs_sw_clr_i == 6'h00;
   endsequence

   vector_at_push_a: assert property (vector_push_o |-> pc_load_o
      && pc_value_o == rst_cause_pkg::PC_INT_VECTOR)
      else $error("bad vector push");
   release_load_a: assert property ($fell(core_reset_o) |-> pc_load_o
      && pc_value_o == rst_cause_pkg::PC_RESET_ADDR)
      else $error("no load at release");
   instr_reset_a: assert property (quiet_s ##0 (reset_instr_i
      && !asleep_i && !watchdog_timeout_i) |=> core_reset_o
      && !power_control_status_o[2] && $stable(status_o)
      && (power_control_status_o | 6'h04)
      == ($past(power_control_status_o) | 6'h04))
      else $error("reset instr flags");
   wdt_reset_a: assert property (quiet_s ##0 (watchdog_timeout_i
      && !asleep_i) |=> core_reset_o && !status_o[4]
      && status_o[3:0] == $past(status_o[3:0])
      && $stable(power_control_status_o))
      else $error("wdog reset flags");
   wdt_wake_a: assert property (quiet_s ##0 (watchdog_timeout_i
      && asleep_i) |=> resume_o && !core_reset_o
      && status_o[4:3] == 2'b00)
      else $error("wdog wake flags");
   int_wake_a: assert property (quiet_s ##0 (int_wake_i && asleep_i
      && !watchdog_timeout_i) |=> resume_o && status_o[4:3] == 2'b10
      && $stable(power_control_status_o))
      else $error("int wake flags");
   brownout_set_a: assert property ($rose(brownout_i) && ce_i
      |=> core_reset_o && status_o[4:3] == 2'b11
      && power_control_status_o
      == (($past(power_control_status_o) & 6'h02) | 6'h0C))
      else $error("brown-out flags wrong");
   brownout_hold_a: assert property (brownout_i && ce_i
      |=> core_reset_o)
      else $error("brown-out not held");
   stack_over_a: assert property ($rose(power_control_status_o[5])
      && $past(pcs_sw_set_i) == 6'h00 |-> core_reset_o
      && $past(stack_fault_reset_enable_i, 2) && $past(push_i, 2))
      else $error("stray overflow flag");
   stack_under_a: assert property ($rose(power_control_status_o[4])
      && $past(pcs_sw_set_i) == 6'h00 |-> core_reset_o
      && $past(stack_fault_reset_enable_i, 2) && $past(pop_i, 2))
      else $error("stray underflow flag");
   pin_flag_a: assert property ($fell(power_control_status_o[3])
      && $past(pcs_sw_clr_i) == 6'h00 |-> core_reset_o
      && !$past(ext_reset_pin_n_i, 3))
      else $error("stray pin flag clear");
endmodule

bind reset_cause_state_loader reset_cause_state_loader_asserts
   reset_cause_state_loader_asserts_inst (.mclk_i, .rst_i, .ce_i,
   .ext_reset_pin_n_i, .brownout_i, .watchdog_timeout_i, .int_wake_i,
   .reset_instr_i, .asleep_i, .stack_fault_reset_enable_i, .push_i,
   .pop_i, .alu_flags_we_i, .pcs_sw_set_i, .pcs_sw_clr_i, .core_reset_o,
   .pc_load_o, .pc_value_o, .resume_o, .vector_push_o, .status_o,
   .power_control_status_o);

// file: bench/reset_cause_state_loader_tb_top.sv
`timescale 1ns/1ps
module reset_cause_state_loader_tb_top;
   typedef struct packed {
      logic       bo, wd, iw, ri, sl, we;
      logic [4:0] alu;
      logic [5:0] set, clr;
      logic [4:0] st;
      logic [5:0] pcs;
      logic [3:0] cs;
      logic       ld, rs;
   } row_t;

   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        ext_reset_pin_n_i = 1'b1;
   logic        brownout_i = 1'b0;
   logic        watchdog_timeout_i = 1'b0;
   logic        int_wake_i = 1'b0;
   logic        reset_instr_i = 1'b0;
   logic        asleep_i = 1'b0;
   logic        global_int_enable_i = 1'b0;
   logic        stack_fault_reset_enable_i = 1'b0;
   logic        push_i = 1'b0;
   logic        pop_i = 1'b0;
   logic        alu_flags_we_i = 1'b0;
   logic [4:0]  alu_flags_i = 5'h00;
   logic [5:0]  pcs_sw_set_i = 6'h00;
   logic [5:0]  pcs_sw_clr_i = 6'h00;
   logic        instr_done, core_reset_o, pc_load_o, resume_o, vector_push_o;
   logic [14:0] pc_value_o, pc_model;
   logic [4:0]  status_o;
   logic [5:0]  power_control_status_o;
   logic [3:0]  last_cause_o;
   int          loads, resumes, err_total, cmp_count, cyc;
   row_t        rows [12];

   always #12.5 mclk_i = ~mclk_i;

   reset_cause_state_loader reset_cause_state_loader_inst (.mclk_i, .rst_i,
      .ce_i, .ext_reset_pin_n_i, .brownout_i, .watchdog_timeout_i,
      .int_wake_i, .reset_instr_i, .asleep_i, .global_int_enable_i,
      .stack_fault_reset_enable_i, .instr_done_i(instr_done), .push_i,
      .pop_i, .alu_flags_we_i, .alu_flags_i, .pcs_sw_set_i, .pcs_sw_clr_i,
      .core_reset_o, .pc_load_o, .pc_value_o, .resume_o, .vector_push_o,
      .status_o, .power_control_status_o, .last_cause_o);

   core_seq_model core_seq_model_inst (.mclk_i, .rst_i,
      .pc_load_i(pc_load_o), .pc_value_i(pc_value_o), .resume_i(resume_o),
      .instr_done_o(instr_done), .pc_o(pc_model), .loads_o(loads),
      .resumes_o(resumes));

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         final_report();
      end
   end

   task automatic step();
      @(posedge mclk_i);
      #1;
   endtask

   task automatic cmp_val(input logic [15:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic run_row(input row_t r);
      int l0;
      int r0;
      l0 = loads;
      r0 = resumes;
      {brownout_i, watchdog_timeout_i, int_wake_i} = {r.bo, r.wd, r.iw};
      {reset_instr_i, asleep_i, alu_flags_we_i} = {r.ri, r.sl, r.we};
      {alu_flags_i, pcs_sw_set_i, pcs_sw_clr_i} = {r.alu, r.set, r.clr};
      step();
      {brownout_i, watchdog_timeout_i, int_wake_i, reset_instr_i} = 4'h0;
      {alu_flags_we_i, pcs_sw_set_i, pcs_sw_clr_i} = 13'h0000;
      cmp_val(16'(status_o), 16'(r.st), "status");
      cmp_val(16'(power_control_status_o), 16'(r.pcs), "pcs");
      cmp_val(16'(last_cause_o), 16'(r.cs), "cause");
      cmp_val(16'(resume_o), 16'(r.rs), "resume");
      asleep_i = 1'b0;
      repeat (4) step();
      cmp_val(16'(loads - l0), 16'(r.ld), "loads");
      cmp_val(16'(resumes - r0), 16'(r.rs), "resumes");
   endtask

   // Pin is synchronised
   task automatic pin_reset(input logic slp, input logic [4:0] st);
      pcs_sw_set_i = 6'h3F;
      step();
      pcs_sw_set_i = 6'h00;
      asleep_i = slp;
      ext_reset_pin_n_i = 1'b0;
      repeat (4) step();
      cmp_val(16'(core_reset_o), 16'h0001, "pin hold");
      cmp_val(16'(status_o), 16'(st), "pin status");
      cmp_val(16'(power_control_status_o), 16'h0037, "pin pcs");
      ext_reset_pin_n_i = 1'b1;
      asleep_i = 1'b0;
      repeat (5) step();
      cmp_val(16'(core_reset_o), 16'h0000, "pin release");
   endtask

   initial begin
      rows[0] = '{0,0,0,0,0,1,5'h05,6'h3F,6'h00,5'h1D,6'h3F,4'h0,0,0};
      rows[1] = '{0,0,0,1,0,0,5'h00,6'h00,6'h00,5'h1D,6'h3B,4'h7,1,0};
      rows[2] = '{0,1,0,0,0,0,5'h00,6'h00,6'h00,5'h0D,6'h3B,4'h4,1,0};
      rows[3] = '{0,0,1,0,1,0,5'h00,6'h00,6'h00,5'h15,6'h3B,4'h6,0,1};
      rows[4] = '{0,1,0,0,1,0,5'h00,6'h00,6'h00,5'h05,6'h3B,4'h5,0,1};
      rows[5] = '{0,0,0,0,0,1,5'h02,6'h3F,6'h00,5'h02,6'h3F,4'h5,0,0};
      rows[6] = '{0,0,1,0,0,0,5'h00,6'h00,6'h00,5'h02,6'h3F,4'h5,0,0};
      rows[7] = '{0,0,0,1,1,0,5'h00,6'h00,6'h00,5'h02,6'h3F,4'h5,0,0};
      rows[8] = '{0,1,0,1,0,0,5'h00,6'h00,6'h00,5'h02,6'h3F,4'h4,1,0};
      rows[9] = '{1,0,0,0,0,0,5'h00,6'h00,6'h00,5'h1A,6'h0E,4'h1,1,0};
      rows[10] = '{0,0,0,0,0,0,5'h00,6'h00,6'h0E,5'h1A,6'h00,4'h1,0,0};
      rows[11] = '{0,1,1,1,0,0,5'h00,6'h00,6'h00,5'h0A,6'h00,4'h4,1,0};
      repeat (8) step();
      rst_i = 1'b0;
      repeat (3) step();
      foreach (rows[i])
         run_row(rows[i]);
      $display("rows done");
      rst_i = 1'b1;
      repeat (2) step();
      cmp_val(16'(status_o), 16'h0018, "reset status");
      cmp_val(16'(power_control_status_o), 16'h000C, "reset pcs");
      cmp_val(16'(core_reset_o), 16'h0001, "reset hold");
      rst_i = 1'b0;
      repeat (3) step();
      cmp_val(16'(loads), 16'h0001, "reset load");
      cmp_val(16'(pc_model), 16'h0000, "reset address");
      $display("reset done");
      pin_reset(1'b0, 5'h18);
      pin_reset(1'b1, 5'h10);
      $display("pins done");
      {global_int_enable_i, asleep_i, int_wake_i} = 3'h7;
      step();
      {asleep_i, int_wake_i} = 2'h0;
      cmp_val(16'(resume_o), 16'h0001, "wake resume");
      cmp_val(16'(status_o), 16'h0010, "wake status");
      repeat (6) step();
      cmp_val(16'(pc_model), 16'h0004, "vector address");
      global_int_enable_i = 1'b0;
      $display("wake done");
      stack_fault_reset_enable_i = 1'b1;
      pcs_sw_clr_i = 6'h30;
      push_i = 1'b1;
      step();
      pcs_sw_clr_i = 6'h00;
      repeat (15) step();
      cmp_val(16'(core_reset_o), 16'h0000, "16 pushes");
      step();
      push_i = 1'b0;
      step();
      cmp_val(16'(core_reset_o), 16'h0001, "overflow hold");
      cmp_val(16'(power_control_status_o), 16'h0027, "overflow");
      repeat (4) step();
      pop_i = 1'b1;
      step();
      pop_i = 1'b0;
      step();
      cmp_val(16'(core_reset_o), 16'h0001, "underflow hold");
      cmp_val(16'(power_control_status_o), 16'h0037, "underflow");
      repeat (4) step();
      stack_fault_reset_enable_i = 1'b0;
      pop_i = 1'b1;
      step();
      pop_i = 1'b0;
      repeat (3) step();
      cmp_val(16'(core_reset_o), 16'h0000, "fault disabled");
      cmp_val(16'(power_control_status_o), 16'h0037, "no flag");
      $display("stack done");
      ce_i = 1'b0;
      reset_instr_i = 1'b1;
      step();
      {ce_i, reset_instr_i} = 2'h2;
      step();
      cmp_val(16'(last_cause_o), 16'h0009, "frozen");
      $display("enable done");
      final_report();
   end
endmodule
